//--- core/cbc_defs.svh
// Offsets, field positions, reset values and timing constants
`ifndef CBC_DEFS_SVH
`define CBC_DEFS_SVH
`define CBC_A_CTRL 8'h00
`define CBC_A_STAT 8'h04
`define CBC_A_LEN 8'h08
`define CBC_A_BOOT 8'h0C
`define CBC_A_GOLD 8'h10
`define CBC_A_SEU 8'h14
`define CBC_A_SEDA 8'h18
`define CBC_A_CRC 8'h1C
`define CBC_C_PORT 0
`define CBC_C_START 3
`define CBC_C_SED 4
`define CBC_C_ERROE 5
`define CBC_C_FRZ 6
`define CBC_C_PAUSE 7
`define CBC_C_WID 8
`define CBC_C_UCLK 10
`define CBC_S_ADDR 8
`define CBC_S_INJ 16
`define CBC_T_LERR 5
`define CBC_T_SERR 7
`define CBC_T_OVF 8
`define CBC_LEN_RST 16'h0040
`define CBC_HDR_VER 4'hA
`define CBC_HDR_CKV 3
`define CBC_SLAVE_SERIAL_PERIPHERAL_MODE_WR 8'h02
`define CBC_SLAVE_SERIAL_PERIPHERAL_MODE_RDSR 8'h05
`define CBC_FL_READ 8'h03
`define CBC_TAP_CFG 8'hC0
`define CBC_CRC_POLY 16'h1021
`define CBC_CRC_INIT 16'hFFFF
`define CBC_FIFO_DEPTH 8
`define CBC_MCLK_DEF 3'h0
`define CBC_CORE_KHZ 50000
`define CBC_MCLK0_KHZ 2400
`define CBC_MCLK1_KHZ 4800
`define CBC_MCLK2_KHZ 9700
`define CBC_MCLK3_KHZ 19400
`define CBC_MCLK4_KHZ 38800
`define CBC_MCLK5_KHZ 62000
// Half period in core cycles, rounded up, never below one
`define CBC_HALF(k) ((((`CBC_CORE_KHZ)+2*(k)-1)/(2*(k))) < 1 ? 1 : \
    (((`CBC_CORE_KHZ)+2*(k)-1)/(2*(k))))
`endif

//--- core/cbc_pkg.sv
// Types shared by the configuration controller
package cbc_pkg;
    typedef enum logic [1:0] {CBC_IDLE, CBC_LOAD, CBC_DONE, CBC_FAIL}
        cbc_state_t;
    typedef enum logic [2:0] {CBC_P_TAP, CBC_P_MFLASH, CBC_P_SPAR,
        CBC_P_SLAVE_SERIAL_PERIPHERAL_MODE, CBC_P_SSER} cbc_port_t;
    typedef enum logic [1:0] {CBC_W_X1, CBC_W_X2, CBC_W_X4} cbc_width_t;
endpackage : cbc_pkg

//--- core/cbc_top.sv
// Configuration load controller with its bitstream FIFO
//
// The APB interface to the registers and the register addresses were decided locally.
`include "cbc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module cbc_fifo #(
    parameter int W = 8,
    parameter int D = `CBC_FIFO_DEPTH
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic clr_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    // Depth must be a power of two
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } cbc_fifo_st_t;
    cbc_fifo_st_t s, next_s;
    logic full, empty;

    assign empty = s.wp == s.rp;
    assign full = (s.wp[AW] != s.rp[AW]) &&
        (s.wp[AW-1:0] == s.rp[AW-1:0]);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = s.mem[s.rp[AW-1:0]];

    always_comb begin
        next_s = s;
        if (clr_i) begin
            next_s.wp = '0;
            next_s.rp = '0;
        end else begin
            if (in_valid_i && !full) begin
                next_s.mem[s.wp[AW-1:0]] = in_data_i;
                next_s.wp = s.wp + 1'b1;
            end
            if (out_ready_i && !empty) begin
                next_s.rp = s.rp + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : cbc_fifo

module cbc_top import cbc_pkg::*; #(
    parameter int CFG_WORDS = 64,
    parameter int IOW = 8
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic lnk_clk_i,
    input wire logic lnk_cs_n_i,
    input wire logic [7:0] lnk_data_i,
    output logic lnk_so_o,
    output logic lnk_so_oe_o,
    output logic flash_clk_o,
    output logic flash_cs_n_o,
    input wire logic [3:0] flash_dq_i,
    output logic [3:0] flash_dq_o,
    output logic [3:0] flash_dq_oe_o,
    input wire logic [IOW-1:0] user_io_i,
    output logic [IOW-1:0] io_o,
    output logic freeze_o,
    output logic done_o,
    output logic soft_err_o,
    output logic mclk_o,
    output logic user_clk_o
);
    localparam int AW = $clog2(CFG_WORDS);
    typedef struct packed {
        logic [2:0] lck;
        logic [1:0] lcs;
        logic [1:0][7:0] ld;
        logic [1:0][3:0] fdq;
        logic [2:0] tck;
        logic [2:0] tms;
        logic [1:0] tdi;
        logic sed_en, erroe, frz_en, pause, uclk_en;
        logic [1:0] wid;
        logic [15:0] len;
        logic [23:0] boot_a, gold_a;
        cbc_state_t st;
        cbc_port_t port;
        logic golden, load_err, sed_err, ovf;
        logic [15:0] idx, crc, crc_rx;
        logic [AW-1:0] sed_a, scan;
        logic [CFG_WORDS-1:0][8:0] mem;
        logic [2:0] msel, mpend;
        logic mpend_v, mclk;
        logic [7:0] hc;
        logic fl_sel, fl_en, fl_cmd, fclk;
        logic [5:0] fl_cnt;
        logic [31:0] fl_sh;
        logic [1:0] fsmp;
        logic [7:0] sh;
        logic [3:0] nb;
        logic sp_mid;
        logic [7:0] sp_cmd, so_sh, ir;
        logic [IOW-1:0] io;
        logic frz, uclk;
        logic [31:0] rdata;
    } cbc_core_st_t;

    cbc_core_st_t s, n;
    logic f_in_v, f_in_rdy, f_out_v, f_out_rdy, f_clr;
    logic [7:0] f_in_d, f_out_d;

    function automatic logic mapped(logic [7:0] a);
        return a inside {`CBC_A_CTRL, `CBC_A_STAT, `CBC_A_LEN, `CBC_A_BOOT,
            `CBC_A_GOLD, `CBC_A_SEU, `CBC_A_SEDA, `CBC_A_CRC};
    endfunction : mapped

    function automatic cbc_port_t to_port(logic [2:0] v);
        return (v > 3'h4) ? CBC_P_MFLASH : cbc_port_t'(v);
    endfunction : to_port

    function automatic logic [7:0] half_of(logic [2:0] sel);
        case (sel)
            3'h0: half_of = 8'(`CBC_HALF(`CBC_MCLK0_KHZ));
            3'h1: half_of = 8'(`CBC_HALF(`CBC_MCLK1_KHZ));
            3'h2: half_of = 8'(`CBC_HALF(`CBC_MCLK2_KHZ));
            3'h3: half_of = 8'(`CBC_HALF(`CBC_MCLK3_KHZ));
            3'h4: half_of = 8'(`CBC_HALF(`CBC_MCLK4_KHZ));
            default: half_of = 8'(`CBC_HALF(`CBC_MCLK5_KHZ));
        endcase
    endfunction : half_of

    function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ `CBC_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc_step

    function automatic cbc_core_st_t restart(cbc_core_st_t x, cbc_port_t p,
            logic [23:0] a);
        cbc_core_st_t y;
        y = x;
        y.st = CBC_LOAD;
        y.port = p;
        y.idx = '0;
        y.crc = `CBC_CRC_INIT;
        y.nb = '0;
        y.sp_mid = 1'b0;
        y.mpend = `CBC_MCLK_DEF;
        y.mpend_v = 1'b1;
        y.fl_sel = 1'b0;
        y.fsmp = '0;
        y.fl_cmd = 1'b1;
        y.fl_cnt = '0;
        y.fl_en = 1'b0;
        y.fl_sh = {`CBC_FL_READ, a};
        return y;
    endfunction : restart

    cbc_fifo #(.W(8), .D(`CBC_FIFO_DEPTH)) u_fifo (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .clr_i(f_clr),
        .in_valid_i(f_in_v),
        .in_data_i(f_in_d),
        .in_ready_o(f_in_rdy),
        .out_valid_o(f_out_v),
        .out_ready_i(f_out_rdy),
        .out_data_o(f_out_d)
    );

    assign f_out_rdy = f_out_v && !s.pause && s.st == CBC_LOAD;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped(paddr_i);
    assign prdata_o = s.rdata;
    assign lnk_so_o = s.so_sh[7];
    assign lnk_so_oe_o = s.port == CBC_P_SLAVE_SERIAL_PERIPHERAL_MODE && !s.lcs[1] &&
        s.sp_cmd == `CBC_SLAVE_SERIAL_PERIPHERAL_MODE_RDSR && s.sp_mid;
    assign flash_clk_o = s.fclk;
    assign flash_cs_n_o = !s.fl_sel;
    assign flash_dq_o = {3'h0, s.fl_sh[31]};
    assign flash_dq_oe_o = {3'h0, s.fl_sel && s.fl_cmd};
    assign io_o = s.io;
    assign freeze_o = s.frz;
    assign done_o = s.st == CBC_DONE;
    assign soft_err_o = s.sed_err && s.erroe;
    assign mclk_o = s.mclk;
    assign user_clk_o = s.uclk;

    always_comb begin
        logic acc, lrise, trise, tmsrise, bit_v, bit_d, byte_v, fail;
        logic [7:0] byte_d, b, st8;
        logic [3:0] w;
        logic [AW-1:0] a;
        n = s;
        f_in_v = 1'b0;
        f_in_d = 8'h00;
        f_clr = 1'b0;
        bit_v = 1'b0;
        bit_d = 1'b0;
        byte_v = 1'b0;
        byte_d = 8'h00;
        fail = 1'b0;
        b = f_out_d;
        a = s.idx[AW-1:0] - 1'b1;
        st8 = {s.st == CBC_DONE, s.load_err, s.golden, s.ovf, 2'b00, s.st};
        w = (s.wid == CBC_W_X4) ? 4'h4 : (s.wid == CBC_W_X2) ? 4'h2 : 4'h1;
        // Synchronisers for the link, flash and test port pins
        n.lck = {s.lck[1:0], lnk_clk_i};
        n.lcs = {s.lcs[0], lnk_cs_n_i};
        n.ld = {s.ld[0], lnk_data_i};
        n.fdq = {s.fdq[0], flash_dq_i};
        n.tck = {s.tck[1:0], tck_i};
        n.tms = {s.tms[1:0], tms_i};
        n.tdi = {s.tdi[0], tdi_i};
        n.fsmp = {s.fsmp[0], 1'b0};
        lrise = s.lck[1] && !s.lck[2];
        trise = s.tck[1] && !s.tck[2];
        tmsrise = s.tms[1] && !s.tms[2];
        acc = psel_i && penable_i && pwrite_i;
        if (psel_i && !penable_i) begin
            case (paddr_i)
                `CBC_A_CTRL: n.rdata = {21'h0, s.uclk_en, s.wid, s.pause,
                    s.frz_en, s.erroe, s.sed_en, 1'b0, s.port};
                `CBC_A_STAT: n.rdata = {17'h0, s.msel, s.port, s.ovf,
                    s.sed_err, s.golden, s.load_err, s.st == CBC_DONE,
                    2'b00, s.st};
                `CBC_A_LEN: n.rdata = {16'h0, s.len};
                `CBC_A_BOOT: n.rdata = {8'h00, s.boot_a};
                `CBC_A_GOLD: n.rdata = {8'h00, s.gold_a};
                `CBC_A_SEDA: n.rdata = 32'(s.sed_a);
                `CBC_A_CRC: n.rdata = {16'h0, s.crc};
                default: n.rdata = 32'h0000_0000;
            endcase
        end
        if (acc) begin
            unique case (paddr_i)
                `CBC_A_CTRL: begin
                    n.sed_en = pwdata_i[`CBC_C_SED];
                    n.erroe = pwdata_i[`CBC_C_ERROE];
                    n.frz_en = pwdata_i[`CBC_C_FRZ];
                    n.pause = pwdata_i[`CBC_C_PAUSE];
                    n.wid = pwdata_i[`CBC_C_WID +: 2];
                    n.uclk_en = pwdata_i[`CBC_C_UCLK];
                    // Port is only latched between cycles
                    if (pwdata_i[`CBC_C_START] && s.st != CBC_LOAD) begin
                        n = restart(n, to_port(pwdata_i[`CBC_C_PORT +: 3]),
                            s.boot_a);
                        n.golden = 1'b0;
                        n.load_err = 1'b0;
                        f_clr = 1'b1;
                    end
                end
                `CBC_A_STAT: begin
                    if (pwdata_i[`CBC_T_LERR]) n.load_err = 1'b0;
                    if (pwdata_i[`CBC_T_SERR]) n.sed_err = 1'b0;
                    if (pwdata_i[`CBC_T_OVF]) n.ovf = 1'b0;
                end
                `CBC_A_LEN: n.len = pwdata_i[15:0];
                `CBC_A_BOOT: n.boot_a = pwdata_i[23:0];
                `CBC_A_GOLD: n.gold_a = pwdata_i[23:0];
                `CBC_A_SEU: begin
                    if (s.st == CBC_DONE) begin
                        if (pwdata_i[`CBC_S_INJ]) begin
                            n.mem[pwdata_i[`CBC_S_ADDR +: AW]][pwdata_i[2:0]] =
                                ~s.mem[pwdata_i[`CBC_S_ADDR +: AW]][pwdata_i[2:0]];
                        end else begin
                            n.mem[pwdata_i[`CBC_S_ADDR +: AW]] =
                                {^pwdata_i[7:0], pwdata_i[7:0]};
                        end
                    end
                end
                default: ;
            endcase
        end
        // Test port instruction overrides any other port in use; a test port load already running is not restarted
        if (trise) begin
            n.ir = {s.tdi[1], s.ir[7:1]};
        end
        if (tmsrise && s.ir == `CBC_TAP_CFG &&
                !(s.st == CBC_LOAD && s.port == CBC_P_TAP)) begin
            n = restart(n, CBC_P_TAP, s.boot_a);
            f_clr = 1'b1;
        end
        // Master clock; new rate applied only at a rising point
        if (s.hc == 8'h00) begin
            n.mclk = !s.mclk;
            if (!s.mclk && s.mpend_v) begin
                n.msel = s.mpend;
                n.mpend_v = 1'b0;
                n.hc = half_of(s.mpend) - 8'h01;
            end else begin
                n.hc = half_of(s.msel) - 8'h01;
            end
        end else begin
            n.hc = s.hc - 8'h01;
        end
        if (s.st == CBC_LOAD) begin
            unique case (s.port)
                CBC_P_MFLASH: begin
                    // Flash clock gated only while low, on a full FIFO
                    if (s.hc == 8'h00 && s.mclk && s.fl_sel) begin
                        n.fl_en = f_in_rdy;
                        if (s.fl_cmd && s.fl_en) n.fl_sh = {s.fl_sh[30:0], 1'b0};
                    end
                    if (s.hc == 8'h00 && !s.mclk && s.fl_en) begin
                        n.fsmp[0] = !s.fl_cmd;
                        if (s.fl_cmd) begin
                            n.fl_cnt = s.fl_cnt + 6'h01;
                            if (s.fl_cnt == 6'h1F) n.fl_cmd = 1'b0;
                        end
                    end
                    // Pins lag the rise by two synchroniser stages
                    if (s.fsmp[1]) begin
                        unique case (w)
                            4'h4: n.sh = {s.sh[3:0], s.fdq[1]};
                            4'h2: n.sh = {s.sh[5:0], s.fdq[1][1:0]};
                            default: n.sh = {s.sh[6:0], s.fdq[1][1]};
                        endcase
                        n.nb = s.nb + w;
                        if (s.nb + w == 4'h8) begin
                            n.nb = 4'h0;
                            f_in_v = 1'b1;
                            f_in_d = n.sh;
                        end
                    end
                    if (!s.fl_sel) n.fl_sel = 1'b1;
                end
                CBC_P_SPAR: begin
                    if (lrise && !s.lcs[1]) begin
                        byte_v = 1'b1;
                        byte_d = s.ld[1];
                    end
                end
                CBC_P_SSER: begin
                    bit_v = lrise;
                    bit_d = s.ld[1][0];
                end
                CBC_P_TAP: begin
                    bit_v = trise && !s.tms[1];
                    bit_d = s.tdi[1];
                end
                CBC_P_SLAVE_SERIAL_PERIPHERAL_MODE: ;
            endcase
        end
        if (s.port == CBC_P_SLAVE_SERIAL_PERIPHERAL_MODE) begin
            if (s.lcs[1]) begin
                n.nb = 4'h0;
                n.sp_mid = 1'b0;
            end else if (lrise) begin
                bit_v = 1'b1;
                bit_d = s.ld[1][0];
                n.so_sh = {s.so_sh[6:0], 1'b0};
            end
        end
        if (bit_v) begin
            n.sh = {s.sh[6:0], bit_d};
            n.nb = s.nb + 4'h1;
            if (s.nb == 4'h7) begin
                n.nb = 4'h0;
                if (s.port != CBC_P_SLAVE_SERIAL_PERIPHERAL_MODE) begin
                    byte_v = 1'b1;
                end else if (!s.sp_mid) begin
                    n.sp_mid = 1'b1;
                    n.sp_cmd = n.sh;
                    if (n.sh == `CBC_SLAVE_SERIAL_PERIPHERAL_MODE_RDSR) n.so_sh = st8;
                end else if (s.sp_cmd == `CBC_SLAVE_SERIAL_PERIPHERAL_MODE_WR &&
                        s.st == CBC_LOAD) begin
                    byte_v = 1'b1;
                end
                byte_d = n.sh;
            end
        end
        if (byte_v) begin
            f_in_v = 1'b1;
            f_in_d = byte_d;
            if (!f_in_rdy) n.ovf = 1'b1;
        end
        // Loader: header, data words, then two check bytes
        if (f_out_rdy) begin
            n.idx = s.idx + 16'h0001;
            if (s.idx == 16'h0000) begin
                if (b[7:4] != `CBC_HDR_VER) begin
                    fail = 1'b1;
                end else if (b[`CBC_HDR_CKV]) begin
                    n.mpend = b[2:0];
                    n.mpend_v = 1'b1;
                end
            end else if (s.idx <= s.len) begin
                if (32'(s.idx) <= CFG_WORDS) n.mem[a] = {^b, b};
                n.crc = crc_step(s.crc, b);
            end else if (s.idx == s.len + 16'h0001) begin
                n.crc_rx = {b, 8'h00};
            end else begin
                if ({s.crc_rx[15:8], b} == s.crc) begin
                    n.st = CBC_DONE;
                    n.fl_sel = 1'b0;
                end else begin
                    fail = 1'b1;
                end
            end
        end
        if (fail) begin
            n.load_err = 1'b1;
            if (s.port == CBC_P_MFLASH && !s.golden) begin
                n = restart(n, CBC_P_MFLASH, s.gold_a);
                n.golden = 1'b1;
                f_clr = 1'b1;
            end else begin
                n.st = CBC_FAIL;
                n.fl_sel = 1'b0;
            end
        end
        // Scan reads only; user outputs are untouched
        if (s.st == CBC_DONE && s.sed_en) begin
            n.scan = (32'(s.scan) == CFG_WORDS - 1) ? '0 : s.scan + 1'b1;
            if (^s.mem[s.scan]) begin
                n.sed_err = 1'b1;
                n.sed_a = s.scan;
            end
        end
        n.frz = s.frz_en && n.st == CBC_LOAD;
        n.io = n.frz ? s.io : user_io_i;
        n.fclk = n.mclk && n.fl_en && n.fl_sel;
        n.uclk = n.mclk && n.st == CBC_DONE && s.uclk_en;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
            s.len <= `CBC_LEN_RST;
            s.msel <= `CBC_MCLK_DEF;
        end else begin
            s <= n;
        end
    end
endmodule : cbc_top
`default_nettype wire

//--- test/cbc_flash_model.sv
// Boot flash memory answering the controller's read command
`timescale 1ns/1ps
`default_nettype none
module cbc_flash_model (
    input wire logic clk_i,
    input wire logic cs_n_i,
    input wire logic dq0_i,
    input wire logic bad_i,
    input wire logic [2:0] w_i,
    input wire logic [55:0] img_i,
    output logic [3:0] dq_o
);
    int n;
    int k;
    logic [23:0] addr;
    logic [55:0] img;
    initial begin
        dq_o = 4'h5;
        n = 0;
        addr = 24'h00_0000;
    end
    // Only images away from address zero break, so a golden image at zero can succeed
    assign img = (bad_i && addr != 24'h00_0000) ? img_i ^ {1'b1, 55'h0} : img_i;
    always @(posedge clk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            n <= 0;
        end else begin
            if (n >= 8 && n < 32) begin
                addr <= {addr[22:0], dq0_i};
            end
            n <= n + 1;
        end
    end
    // Released lines toggle rather than keep stale data
    always @(negedge clk_i or posedge cs_n_i) begin
        k = (n - 32) * int'(w_i);
        if (cs_n_i || n < 32 || k >= 56) begin
            dq_o <= ~dq_o;
        end else if (w_i == 3'h1) begin
            dq_o <= {2'b00, img[55 - k], ~dq_o[0]};
        end else if (w_i == 3'h2) begin
            dq_o <= {2'b00, img[55 - k -: 2]};
        end else begin
            dq_o <= img[55 - k -: 4];
        end
    end
endmodule : cbc_flash_model
`default_nettype wire

//--- test/cbc_top_assertions.sv
// Port-level checks of the configuration load controller
`timescale 1ns/1ps
`default_nettype none
module cbc_top_assertions #(
    parameter int IOW = 8
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic lnk_cs_n_i,
    input wire logic lnk_so_oe_o,
    input wire logic flash_clk_o,
    input wire logic flash_cs_n_o,
    input wire logic [3:0] flash_dq_oe_o,
    input wire logic [IOW-1:0] io_o,
    input wire logic freeze_o,
    input wire logic done_o,
    input wire logic mclk_o,
    input wire logic user_clk_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Select is resynchronised, so allow the sampling lag
    sequence deselected;
        lnk_cs_n_i [*5];
    endsequence
    // Slowest half period is 11 core cycles
    sequence mclk_moves;
        ##[1:16] $changed(mclk_o);
    endsequence
    sequence settled_done;
        done_o && $past(done_o);
    endsequence
    a_mclk_free_run: assert property (1'b1 |-> mclk_moves)
        else $error("master clock stalled");
    a_user_clk_gate: assert property (user_clk_o |-> done_o)
        else $error("user clock before configuration done");
    a_freeze_holds_io: assert property (
        freeze_o && $past(freeze_o) |-> $stable(io_o))
        else $error("user outputs moved while frozen");
    a_unfrozen_done: assert property (settled_done |-> !freeze_o)
        else $error("freeze held after configuration done");
    a_port_released: assert property (settled_done |-> flash_cs_n_o)
        else $error("flash still selected after done");
    a_flash_idle_dq: assert property (
        flash_cs_n_o |-> flash_dq_oe_o == 4'h0)
        else $error("flash lines driven while deselected");
    a_upper_dq_input: assert property (flash_dq_oe_o[3:1] == 3'h0)
        else $error("flash data lines driven by controller");
    a_flash_clk_framed: assert property (
        $rose(flash_clk_o) |-> !flash_cs_n_o)
        else $error("flash clock outside select");
    a_so_released: assert property (deselected |-> !lnk_so_oe_o)
        else $error("serial out driven while deselected");
endmodule : cbc_top_assertions

bind cbc_top cbc_top_assertions #(.IOW(IOW)) chk_u (.core_clk_i, .rst_n_i,
    .lnk_cs_n_i, .lnk_so_oe_o, .flash_clk_o, .flash_cs_n_o, .flash_dq_oe_o,
    .io_o, .freeze_o, .done_o, .mclk_o, .user_clk_o);
`default_nettype wire

//--- test/tb_top.sv
// Register-level tests of the configuration load controller
`include "cbc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk_i, rst_n_i, psel, penable, pwrite, lnk_clk, lnk_cs_n;
    logic perr, pslverr, pready, freeze, done, soft_err, fclk, fcs_n, bad;
    logic [7:0] paddr, lnk_data, user_io, io;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] fdq_i, fdq_o, fdq_oe, mdq;
    logic [2:0] fw;
    logic [55:0] img;
    logic tck, tms, tdi;
    int fail_count, check_count;
    assign fdq_i = (fdq_oe & fdq_o) | (~fdq_oe & mdq);
    cbc_top #(.CFG_WORDS(64), .IOW(8)) dut_u (.core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .lnk_clk_i(lnk_clk),
        .lnk_cs_n_i(lnk_cs_n), .lnk_data_i(lnk_data), .lnk_so_o(),
        .lnk_so_oe_o(), .flash_clk_o(fclk), .flash_cs_n_o(fcs_n),
        .flash_dq_i(fdq_i), .flash_dq_o(fdq_o), .flash_dq_oe_o(fdq_oe),
        .user_io_i(user_io), .io_o(io), .freeze_o(freeze), .done_o(done),
        .soft_err_o(soft_err), .mclk_o(), .user_clk_o());
    cbc_flash_model flash_u (.clk_i(fclk), .cs_n_i(fcs_n), .dq0_i(fdq_o[0]),
        .bad_i(bad), .w_i(fw), .img_i(img), .dq_o(mdq));
    task automatic check(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        do @(posedge core_clk_i); while (pready !== 1'b1);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [15:0] crc(input logic [31:0] d);
        logic [15:0] c;
        c = `CBC_CRC_INIT;
        for (int i = 31; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `CBC_CRC_POLY : 16'h0000);
        end
        return c;
    endfunction : crc
    task automatic load(input logic [31:0] ctrl, input logic [7:0] hdr,
            input logic [31:0] d);
        img = {hdr, d, crc(d)};
        apb(1'b1, `CBC_A_LEN, 32'h0000_0004);
        apb(1'b1, `CBC_A_CTRL, ctrl | 32'h0000_0008);
    endtask : load
    task automatic wait_end();
        do apb(1'b0, `CBC_A_STAT, 32'h0000_0000); while (q[1:0] < 2'h2);
    endtask : wait_end
    task automatic send(input logic [7:0] b);
        lnk_data <= b;
        repeat (4) @(posedge core_clk_i);
        lnk_clk <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        lnk_clk <= 1'b0;
    endtask : send
    task automatic tap(input logic m, d);
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge core_clk_i);
        tck <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        tck <= 1'b0;
    endtask : tap
    task automatic end_of_test();
        if (fail_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    initial begin
        repeat (100000) @(posedge core_clk_i);
        fail_count++;
        end_of_test();
    end
    initial begin
        {rst_n_i, psel, penable, pwrite, lnk_clk, bad, tck, tms, tdi} = 9'h000;
        {paddr, pwdata, lnk_data, img} = 104'h0;
        lnk_cs_n = 1'b1;
        user_io = 8'h5A;
        fw = 3'h1;
        repeat (12) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        apb(1'b0, `CBC_A_STAT, 32'h0000_0000);
        check("idle status", q, 32'h0000_0000);
        apb(1'b0, `CBC_A_LEN, 32'h0000_0000);
        check("length reset", q, `CBC_LEN_RST);
        apb(1'b0, 8'h20, 32'h0000_0000);
        check("unmapped", {q[30:0], perr}, 32'h0000_0001);
        for (int i = 0; i < 6; i++) begin
            fw = 3'(1 << (i % 3));
            load(32'(1 + ((i % 3) << 8)), 8'(8'hA8 + i), 32'(32'h1122_3340 + i));
            wait_end();
            check("flash load", q, 32'(32'h0000_0212 | (i << 12)));
        end
        fw = 3'h1;
        load(32'h0000_0001, 8'hA0, 32'h0000_CAFE);
        wait_end();
        check("default clock", q, 32'h0000_0212);
        bad = 1'b1;
        apb(1'b1, `CBC_A_BOOT, 32'h0000_0100);
        load(32'h0000_0001, 8'hAA, 32'h0BAD_F00D);
        wait_end();
        check("golden fallback", q, 32'h0000_2272);
        apb(1'b1, `CBC_A_GOLD, 32'h0000_0200);
        load(32'h0000_0001, 8'hAA, 32'h0BAD_F00D);
        wait_end();
        check("both images bad", q, 32'h0000_0263);
        apb(1'b1, `CBC_A_STAT, 32'h0000_0020);
        apb(1'b0, `CBC_A_STAT, 32'h0000_0000);
        check("error cleared", q, 32'h0000_0243);
        load(32'h0000_00C2, 8'hA0, 32'hDEAD_BEEF);
        user_io <= 8'hC3;
        lnk_cs_n <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            send(i < 7 ? img[55 - 8 * i -: 8] : 8'hEE);
        end
        lnk_cs_n <= 1'b1;
        apb(1'b1, `CBC_A_CTRL, 32'h0000_00CC);
        apb(1'b0, `CBC_A_STAT, 32'h0000_0000);
        check("port held", q & 32'h0000_0F03, 32'h0000_0501);
        check("frozen io", {freeze, io}, 32'h0000_015A);
        apb(1'b1, `CBC_A_CTRL, 32'h0000_0042);
        wait_end();
        check("parallel load", q & 32'h0000_7F13, 32'h0000_0512);
        repeat (4) @(posedge core_clk_i);
        check("io released", {freeze, io}, 32'h0000_00C3);
        apb(1'b1, `CBC_A_CTRL, 32'h0000_0412);
        apb(1'b1, `CBC_A_SEU, 32'h0001_0000);
        repeat (70) @(posedge core_clk_i);
        apb(1'b0, `CBC_A_STAT, 32'h0000_0000);
        check("error found", {soft_err, q[7]}, 32'h0000_0001);
        apb(1'b1, `CBC_A_CTRL, 32'h0000_0432);
        repeat (2) @(posedge core_clk_i);
        check("error output", soft_err, 32'h0000_0001);
        apb(1'b1, `CBC_A_SEU, 32'h0000_00DE);
        apb(1'b1, `CBC_A_STAT, 32'h0000_0080);
        repeat (70) @(posedge core_clk_i);
        apb(1'b0, `CBC_A_STAT, 32'h0000_0000);
        check("corrected", {soft_err, q[7], q[1:0]}, 32'h0000_0002);
        for (int i = 0; i < 9; i++) tap(i == 8, i inside {6, 7});
        for (int i = 55; i >= 0; i--) tap(1'b0, img[i]);
        wait_end();
        check("test port load", q & 32'h0000_0E13, 32'h0000_0012);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
